// ---- logic/tx_request_consts.vh ----
// Constants for the transmit request, buffer commit and frame length logic
`ifndef TX_REQUEST_CONSTS_VH
`define TX_REQUEST_CONSTS_VH
// ----------------------------------------------------------------
// Paged register offsets
// ----------------------------------------------------------------
`define OFS_ISQ 12'h120
`define OFS_BUS_STATUS 12'h138
`define OFS_TX_COMMAND 12'h144
`define OFS_TX_LENGTH 12'h146
`define OFS_TX_IRQ_CFG 12'h106
`define OFS_BUF_IRQ_CFG 12'h10A
`define OFS_TX_EVENT 12'h128
`define OFS_BUF_EVENT 12'h12C
`define OFS_FRAME_WIN 12'hA00
`define OFS_NONE 12'hFFF
// ----------------------------------------------------------------
// I/O port offsets
// ----------------------------------------------------------------
`define IO_DATA 4'h0
`define IO_TX_COMMAND 4'h4
`define IO_TX_LENGTH 4'h6
`define IO_ISQ 4'h8
`define IO_PAGE_PTR 4'hA
`define IO_PAGE_DATA 4'hC
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_START_LO 6
`define BIT_START_HI 7
`define BIT_FLUSH 8
`define BIT_CRC_INHIBIT 12
`define BIT_PAD_DISABLE 13
`define BIT_BID_ERROR 7
`define BIT_READY_NOW 8
`define BIT_SPACE_IRQ_EN 8
`define BIT_UNDERRUN_IRQ_EN 9
`define BIT_TRANSMIT_OK_EVENT_IRQ_EN 8
`define BIT_SPACE_EVENT 8
`define BIT_UNDERRUN 9
`define BIT_TRANSMIT_OK_EVENT 8
`define BIT_LATE_COLL 9
`define BIT_JABBER 10
`define BIT_EXCESS_COLL 15
// ----------------------------------------------------------------
// Event register codes in the low bits, reset values
// ----------------------------------------------------------------
`define CODE_TX_EVENT 16'h0008
`define CODE_BUF_EVENT 16'h000C
`define RESET_WORD 16'h0000
`define RESET_PTR 12'h000
// ----------------------------------------------------------------
// Frame lengths in bytes
// ----------------------------------------------------------------
`define LEN_MIN 16'h0003
`define LEN_PAD 16'h003C
`define LEN_MAX_CRC 16'h05EA
`define LEN_MAX_RAW 16'h05EE
`define START_AFTER_A 12'h005
`define START_AFTER_B 12'h17D
`define START_AFTER_C 12'h3FD
`endif

// ---- logic/tx_request_buffer_commit.v ----
// Transmit request, buffer commit and frame hand-over for a 10 Mb/s MAC
`timescale 1ns/1ns
`include "tx_request_consts.vh"
module tx_request_buffer_commit #(
  parameter BUF_WORDS = 760,
  parameter AW = 10
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Host register access
  input wire i_io_sel,
  input wire [11:0] i_addr,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  output wire o_intrq,
  // Transmit engine side
  output reg o_tx_start,
  output reg [15:0] o_tx_len,
  output reg o_tx_crc_append,
  output reg o_tx_abort,
  input wire i_tx_word_req,
  output reg [15:0] o_tx_word,
  output reg o_tx_word_valid,
  input wire i_tx_ok,
  input wire i_tx_excess_coll,
  input wire i_tx_jabber,
  input wire i_tx_late_coll
);

  // ----------------------------------------------------------------
  // States and declarations
  // ----------------------------------------------------------------
  localparam S_IDLE = 5'b00001;
  localparam S_CMD = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_GRANT = 5'b01000;
  localparam S_FILL = 5'b10000;
  localparam [10:0] BUF_W11 = BUF_WORDS[10:0];

  reg [15:0] mem [0:BUF_WORDS-1];
  reg [4:0] state_reg;
  reg [15:0] cmd_reg, len_reg, buf_cfg_reg, tx_cfg_reg;
  reg [11:0] ptr_reg;
  reg bid_err_reg, rdy_now_reg, rdy_ev_reg, underrun_reg;
  reg transmit_ok_event_reg, excess_reg, jabber_reg, late_reg;
  reg started_reg, busy_reg;
  reg [10:0] wr_cnt_reg, rd_ptr_reg;
  reg [15:0] rd_next;
  wire [11:0] wr_ofs, rd_ofs;
  wire [10:0] len_words;
  wire len_ok, space_ok, fully, buf_any, tx_any, isq_buf, isq_tx;
  wire data_wr, start_hit, underrun_hit;
  reg [11:0] start_thr;

  // Map an access to its paged offset; only the I/O port uses the pointer page
  function [11:0] paged_ofs;
    input io;
    input [11:0] addr;
    input [11:0] ptr;
    begin
      if (!io)
        paged_ofs = addr;
      else
      begin
        case (addr[3:0])
          `IO_DATA: paged_ofs = `OFS_FRAME_WIN;
          `IO_TX_COMMAND: paged_ofs = `OFS_TX_COMMAND;
          `IO_TX_LENGTH: paged_ofs = `OFS_TX_LENGTH;
          `IO_ISQ: paged_ofs = `OFS_ISQ;
          `IO_PAGE_DATA: paged_ofs = ptr;
          default: paged_ofs = `OFS_NONE;
        endcase
      end
    end
  endfunction

  assign wr_ofs = paged_ofs(i_io_sel, i_addr, ptr_reg);
  assign rd_ofs = paged_ofs(i_io_sel, i_addr, ptr_reg);

  // ----------------------------------------------------------------
  // Length, space and start decisions
  // ----------------------------------------------------------------
  // Below 3 never sent; above 1514 only with CRC inhibited, never above 1518
  assign len_ok = (len_reg >= `LEN_MIN) && ((len_reg <= `LEN_MAX_CRC) ||
    (cmd_reg[`BIT_CRC_INHIBIT] && (len_reg <= `LEN_MAX_RAW)));
  assign len_words = len_reg[11:1] + {10'h000, len_reg[0]};
  // One frame owns the buffer at a time, so space means the line is idle
  assign space_ok = !busy_reg && (len_words <= BUF_W11);
  assign fully = (wr_cnt_reg >= len_words);
  assign data_wr = i_wr_en && (i_io_sel ? (i_addr[3:0] == `IO_DATA) : (i_addr >= `OFS_FRAME_WIN));
  assign buf_any = rdy_ev_reg | underrun_reg;
  assign tx_any = transmit_ok_event_reg | excess_reg | jabber_reg | late_reg;
  assign isq_buf = i_rd_en && (rd_ofs == `OFS_ISQ) && buf_any;
  assign isq_tx = i_rd_en && (rd_ofs == `OFS_ISQ) && !buf_any && tx_any;

  // Start threshold from the two-bit start field, bit 6 first
  always @*
  begin
    case ({cmd_reg[`BIT_START_LO], cmd_reg[`BIT_START_HI]})
      2'b00: start_thr = `START_AFTER_A;
      2'b01: start_thr = `START_AFTER_B;
      2'b10: start_thr = `START_AFTER_C;
      default: start_thr = 12'hFFF;
    endcase
  end

  assign start_hit = (state_reg == S_FILL) && !started_reg &&
    (({wr_cnt_reg, 1'b0} >= start_thr) || fully);
  // Engine wants a word not yet written while the frame is incomplete
  assign underrun_hit = i_tx_word_req && started_reg && !fully &&
    (rd_ptr_reg >= wr_cnt_reg);

  // Interrupt line gated by each enable
  assign o_intrq = (rdy_ev_reg & buf_cfg_reg[`BIT_SPACE_IRQ_EN]) |
    (underrun_reg & buf_cfg_reg[`BIT_UNDERRUN_IRQ_EN]) |
    (transmit_ok_event_reg & tx_cfg_reg[`BIT_TRANSMIT_OK_EVENT_IRQ_EN]);

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always @*
  begin
    rd_next = `RESET_WORD;
    if (i_io_sel && (i_addr[3:0] == `IO_PAGE_PTR))
      rd_next = {4'h0, ptr_reg};
    else
    begin
      case (rd_ofs)
        `OFS_BUS_STATUS: rd_next = {7'h00, rdy_now_reg, bid_err_reg, 7'h00};
        `OFS_TX_COMMAND: rd_next = cmd_reg;
        `OFS_BUF_IRQ_CFG: rd_next = buf_cfg_reg;
        `OFS_TX_IRQ_CFG: rd_next = tx_cfg_reg;
        `OFS_BUF_EVENT: rd_next = `CODE_BUF_EVENT | {6'h00, underrun_reg, rdy_ev_reg, 8'h00};
        `OFS_TX_EVENT: rd_next = `CODE_TX_EVENT | {excess_reg, 4'h0, jabber_reg, late_reg,
          transmit_ok_event_reg, 8'h00};
        `OFS_ISQ:
        begin
          // Buffer events are served before transmit events
          if (buf_any)
            rd_next = `CODE_BUF_EVENT | {6'h00, underrun_reg, rdy_ev_reg, 8'h00};
          else if (tx_any)
            rd_next = `CODE_TX_EVENT | {excess_reg, 4'h0, jabber_reg, late_reg,
              transmit_ok_event_reg, 8'h00};
        end
        default: rd_next = `RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Buffer storage
  // ----------------------------------------------------------------
  // Words land in order; writes outside a committed frame are dropped
  always @(posedge i_sys_clk)
  begin
    if (data_wr && (state_reg == S_FILL) && !fully)
      mem[wr_cnt_reg[AW-1:0]] <= i_wdata;
    o_tx_word <= mem[rd_ptr_reg[AW-1:0]];
  end

  // ----------------------------------------------------------------
  // Control, registers and events
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg <= S_IDLE;
      cmd_reg <= `RESET_WORD;
      len_reg <= `RESET_WORD;
      buf_cfg_reg <= `RESET_WORD;
      tx_cfg_reg <= `RESET_WORD;
      ptr_reg <= `RESET_PTR;
      bid_err_reg <= 1'b0;
      rdy_now_reg <= 1'b0;
      rdy_ev_reg <= 1'b0;
      underrun_reg <= 1'b0;
      transmit_ok_event_reg <= 1'b0;
      excess_reg <= 1'b0;
      jabber_reg <= 1'b0;
      late_reg <= 1'b0;
      started_reg <= 1'b0;
      busy_reg <= 1'b0;
      wr_cnt_reg <= 11'h000;
      rd_ptr_reg <= 11'h000;
      o_rdata <= `RESET_WORD;
      o_tx_start <= 1'b0;
      o_tx_len <= `RESET_WORD;
      o_tx_crc_append <= 1'b0;
      o_tx_abort <= 1'b0;
      o_tx_word_valid <= 1'b0;
    end
    else
    begin
      o_tx_start <= 1'b0;
      o_tx_abort <= 1'b0;
      o_tx_word_valid <= 1'b0;
      if (i_rd_en)
        o_rdata <= rd_next;
      // Event reads clear; a new event in the same cycle wins below
      if (isq_buf || (i_rd_en && (rd_ofs == `OFS_BUF_EVENT)))
      begin
        rdy_ev_reg <= 1'b0;
        underrun_reg <= 1'b0;
      end
      if (isq_tx || (i_rd_en && (rd_ofs == `OFS_TX_EVENT)))
      begin
        transmit_ok_event_reg <= 1'b0;
        excess_reg <= 1'b0;
        jabber_reg <= 1'b0;
        late_reg <= 1'b0;
      end
      // Plain configuration writes
      if (i_wr_en && i_io_sel && (i_addr[3:0] == `IO_PAGE_PTR))
        ptr_reg <= i_wdata[11:0];
      if (i_wr_en && (wr_ofs == `OFS_BUF_IRQ_CFG))
        buf_cfg_reg <= i_wdata;
      if (i_wr_en && (wr_ofs == `OFS_TX_IRQ_CFG))
        tx_cfg_reg <= i_wdata;
      // Bid sequencing
      case (state_reg)
        S_CMD:
        begin
          if (i_wr_en && (wr_ofs == `OFS_TX_LENGTH))
          begin
            len_reg <= i_wdata;
            state_reg <= S_GRANT;
          end
        end
        S_GRANT:
        begin
          // Length just captured: judge it once, then wait for the read
          if (!rdy_now_reg && !rdy_ev_reg)
          begin
            if (!len_ok)
            begin
              bid_err_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
            else if (space_ok)
              rdy_now_reg <= 1'b1;
            else
              state_reg <= S_WAIT;
          end
          else if ((i_rd_en && (rd_ofs == `OFS_BUS_STATUS) && rdy_now_reg) ||
            (isq_buf && rdy_ev_reg))
          begin
            state_reg <= S_FILL;
            rdy_now_reg <= 1'b0;
            // Space is only granted on an idle line, so the old frame is done
            started_reg <= 1'b0;
            wr_cnt_reg <= 11'h000;
          end
        end
        S_WAIT:
        begin
          if (space_ok)
          begin
            if (buf_cfg_reg[`BIT_SPACE_IRQ_EN])
              rdy_ev_reg <= 1'b1;
            else
              rdy_now_reg <= 1'b1;
          end
          if (space_ok)
            state_reg <= S_GRANT;
        end
        S_FILL:
        begin
          if (data_wr && !fully)
            wr_cnt_reg <= wr_cnt_reg + 11'h001;
          if (start_hit)
          begin
            started_reg <= 1'b1;
            busy_reg <= 1'b1;
            rd_ptr_reg <= 11'h000;
            o_tx_start <= 1'b1;
            // Pad unless disabled, CRC or no CRC does not change it
            o_tx_len <= (!cmd_reg[`BIT_PAD_DISABLE] && (len_reg < `LEN_PAD)) ?
              `LEN_PAD : len_reg;
            o_tx_crc_append <= !cmd_reg[`BIT_CRC_INHIBIT];
          end
          if (started_reg && fully)
            state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
      // Command write: flush wins over a bid, and a filling frame keeps its space
      if (i_wr_en && (wr_ofs == `OFS_TX_COMMAND))
      begin
        if (i_wdata[`BIT_FLUSH])
        begin
          cmd_reg <= i_wdata;
          state_reg <= S_IDLE;
          busy_reg <= 1'b0;
          started_reg <= 1'b0;
          rdy_now_reg <= 1'b0;
          o_tx_abort <= busy_reg | (state_reg == S_FILL);
        end
        else if (state_reg != S_FILL)
        begin
          // A frame still on the line keeps fetching its words
          cmd_reg <= i_wdata;
          bid_err_reg <= 1'b0;
          rdy_now_reg <= 1'b0;
          state_reg <= S_CMD;
        end
      end
      // Engine pulls words from the buffer
      if (i_tx_word_req && started_reg && !underrun_hit)
      begin
        rd_ptr_reg <= rd_ptr_reg + 11'h001;
        o_tx_word_valid <= 1'b1;
      end
      if (underrun_hit)
      begin
        underrun_reg <= 1'b1;
        o_tx_abort <= 1'b1;
        busy_reg <= 1'b0;
        started_reg <= 1'b0;
        state_reg <= S_IDLE;
      end
      // Line results for a handed-over frame
      if (busy_reg && !underrun_hit)
      begin
        if (i_tx_ok)
          transmit_ok_event_reg <= 1'b1;
        if (i_tx_excess_coll)
          excess_reg <= 1'b1;
        if (i_tx_jabber)
          jabber_reg <= 1'b1;
        if (i_tx_late_coll)
          late_reg <= 1'b1;
        if (i_tx_ok | i_tx_excess_coll | i_tx_jabber | i_tx_late_coll)
        begin
          busy_reg <= 1'b0;
          if (state_reg == S_IDLE)
            started_reg <= 1'b0;
        end
      end
    end
  end

endmodule

// ---- test/tx_req_asserts.sv ----
// Port timing checker for the transmit request block
`timescale 1ns/1ns
`include "tx_request_consts.vh"
module tx_req_asserts (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Host register access
  input wire i_io_sel,
  input wire [11:0] i_addr,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [15:0] i_wdata,
  input wire [15:0] o_rdata,
  // Transmit engine side
  input wire o_tx_start,
  input wire [15:0] o_tx_len,
  input wire o_tx_crc_append,
  input wire o_tx_abort,
  input wire i_tx_word_req,
  input wire o_tx_word_valid
);
  // ----------------------------------------
  // Bid steps, memory mode only
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // Flush commands excluded, their length write follows other rules
  sequence s_cmd;
    i_wr_en && !i_io_sel && i_addr == `OFS_TX_COMMAND && !i_wdata[`BIT_FLUSH];
  endsequence
  sequence s_len(lo, hi);
    i_wr_en && !i_io_sel && i_addr == `OFS_TX_LENGTH && i_wdata >= lo && i_wdata <= hi;
  endsequence
  sequence s_rd_status;
    i_rd_en && !i_io_sel && i_addr == `OFS_BUS_STATUS;
  endsequence
  sequence s_bid(lo, hi);
    s_cmd ##1 !i_wr_en ##1 s_len(lo, hi) ##1 !i_wr_en ##1 s_rd_status;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_bid_err;
    s_bid(16'h0000, 16'h0002) |=> o_rdata[`BIT_BID_ERROR];
  endproperty
  a_bid_err: assert property (p_bid_err)
    else $error("bid error flag missing after short length");
  property p_bid_ok;
    s_bid(`LEN_MIN, `LEN_MAX_CRC) |=> !o_rdata[`BIT_BID_ERROR];
  endproperty
  a_bid_ok: assert property (p_bid_ok)
    else $error("bid error flag set after good length");
  property p_unmapped;
    i_rd_en && !i_io_sel && i_addr == 12'h300 |=> o_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdata_hold;
    !$past(i_rd_en) |-> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_len_range;
    o_tx_start |-> o_tx_len >= `LEN_MIN && o_tx_len <= `LEN_MAX_RAW;
  endproperty
  a_len_range: assert property (p_len_range)
    else $error("frame length out of range at start");
  property p_crc_len;
    o_tx_start && o_tx_crc_append |-> o_tx_len <= `LEN_MAX_CRC;
  endproperty
  a_crc_len: assert property (p_crc_len)
    else $error("long frame started with CRC");
  property p_len_held;
    !o_tx_start |-> $stable(o_tx_len) && $stable(o_tx_crc_append);
  endproperty
  a_len_held: assert property (p_len_held)
    else $error("frame length moved between starts");
  property p_start_pulse;
    o_tx_start |=> !o_tx_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_abort_pulse;
    o_tx_abort |=> !o_tx_abort [*2];
  endproperty
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("abort longer than one cycle");
  property p_word_cause;
    o_tx_word_valid |-> $past(i_tx_word_req);
  endproperty
  a_word_cause: assert property (p_word_cause)
    else $error("word given without request");
endmodule

// ---- test/tx_engine_model.sv ----
// Behavioural transmit engine on the far side of the block
`timescale 1ns/1ns
module tx_engine_model (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Block side
  input wire i_start,
  input wire i_abort,
  // Bench controls
  input wire [15:0] i_words,
  input wire [7:0] i_gap,
  input wire [1:0] i_result,
  // Answers: ok, excess collision, jabber, late collision
  output reg o_word_req,
  output reg [3:0] o_result
);
  reg ab_seen;
  integer k, g;
  // Fetch words until done or aborted, then one result pulse unless aborted; abort is
  // watched on every edge since the pulse may fall between two requests
  initial
  begin
    o_word_req = 1'b0;
    o_result = 4'h0;
    ab_seen = 1'b0;
    forever
    begin
      @(posedge i_sys_clk);
      if (i_sys_rst === 1'b0 && i_start === 1'b1)
      begin
        ab_seen = 1'b0;
        for (k = 0; k < i_words && !ab_seen; k = k + 1)
        begin
          o_word_req <= 1'b1;
          @(posedge i_sys_clk);
          o_word_req <= 1'b0;
          if (i_abort === 1'b1)
            ab_seen = 1'b1;
          for (g = 0; g < i_gap && !ab_seen; g = g + 1)
          begin
            @(posedge i_sys_clk);
            if (i_abort === 1'b1)
              ab_seen = 1'b1;
          end
        end
        if (!ab_seen)
          o_result <= 4'h1 << i_result;
        @(posedge i_sys_clk);
        o_result <= 4'h0;
      end
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the transmit request block
`timescale 1ns/1ns
`include "tx_request_consts.vh"
module tb_top;
  reg i_sys_clk = 1'b0;
  reg i_sys_rst = 1'b1;
  reg i_io_sel = 1'b0;
  reg [11:0] i_addr = 12'h000;
  reg i_wr_en = 1'b0;
  reg i_rd_en = 1'b0;
  reg [15:0] i_wdata = 16'h0000;
  wire [15:0] o_rdata, o_tx_len, o_tx_word;
  wire o_intrq, o_tx_start, o_tx_crc_append, o_tx_abort, o_tx_word_valid;
  wire i_tx_word_req, i_tx_ok, i_tx_excess_coll, i_tx_jabber, i_tx_late_coll;
  reg [1:0] res = 2'h0;
  reg [15:0] nwords = 16'h0000;
  reg [7:0] gap = 8'h02;
  reg txie = 1'b0;
  reg [15:0] rv;
  integer n_mismatch = 0, n_compared = 0, widx = 0, n_start = 0, n_abort = 0, n_done = 0;
  tx_request_buffer_commit tx_request_buffer_commit_inst (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_io_sel(i_io_sel), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_intrq(o_intrq),
    .o_tx_start(o_tx_start), .o_tx_len(o_tx_len), .o_tx_crc_append(o_tx_crc_append),
    .o_tx_abort(o_tx_abort), .i_tx_word_req(i_tx_word_req), .o_tx_word(o_tx_word),
    .o_tx_word_valid(o_tx_word_valid), .i_tx_ok(i_tx_ok),
    .i_tx_excess_coll(i_tx_excess_coll), .i_tx_jabber(i_tx_jabber),
    .i_tx_late_coll(i_tx_late_coll));
  tx_engine_model tx_engine_model_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_start(o_tx_start), .i_abort(o_tx_abort), .i_words(nwords), .i_gap(gap),
    .i_result(res), .o_word_req(i_tx_word_req),
    .o_result({i_tx_late_coll, i_tx_jabber, i_tx_excess_coll, i_tx_ok}));
  // 100 ns clock
  initial
  begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  function [15:0] wpat(input integer i);
    wpat = 16'hC3A5 ^ i[15:0];
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Strobe then one idle cycle, so a length is judged before a read
  task wr(input io, input [11:0] a, input [15:0] d);
  begin
    i_io_sel <= io;
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
    @(posedge i_sys_clk);
  end
  endtask
  task rd(input io, input [11:0] a, output [15:0] d);
  begin
    i_io_sel <= io;
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_sys_clk);
  end
  endtask
  task bid(input io, input [15:0] cmd, input [15:0] len);
  begin
    wr(io, io ? {8'h00, `IO_TX_COMMAND} : `OFS_TX_COMMAND, cmd);
    wr(io, io ? {8'h00, `IO_TX_LENGTH} : `OFS_TX_LENGTH, len);
  end
  endtask
  task stat(input io, output [15:0] d);
  begin
    if (io)
      wr(1'b1, {8'h00, `IO_PAGE_PTR}, 16'h0138);
    rd(io, io ? {8'h00, `IO_PAGE_DATA} : `OFS_BUS_STATUS, d);
  end
  endtask
  task data(input io, input integer n);
    integer i;
  begin
    for (i = 0; i < n; i = i + 1)
      wr(io, io ? {8'h00, `IO_DATA} : `OFS_FRAME_WIN + 2 * i, wpat(i));
  end
  endtask
  task wait_start(input integer s0);
    integer i;
  begin
    for (i = 0; i < 40 && n_start == s0; i = i + 1)
      @(posedge i_sys_clk);
    chk(n_start - s0, 16'h0001);
  end
  endtask
  // Pulse counters and in-order check of each word given to the engine
  always @(posedge i_sys_clk)
  begin
    if (o_tx_start === 1'b1)
    begin
      n_start = n_start + 1;
      widx = 0;
    end
    if (o_tx_abort === 1'b1)
      n_abort = n_abort + 1;
    if ((i_tx_ok | i_tx_excess_coll | i_tx_jabber | i_tx_late_coll) === 1'b1)
      n_done = n_done + 1;
    if (o_tx_word_valid === 1'b1)
    begin
      chk(o_tx_word, wpat(widx));
      widx = widx + 1;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task send(input io, input [15:0] cmd, input [15:0] len, input [15:0] el, input ec,
            input [1:0] r);
    integer i, s0;
  begin
    res <= r;
    nwords <= (len + 16'h0001) >> 1;
    s0 = n_start;
    bid(io, cmd, len);
    stat(io, rv);
    chk(rv & 16'h0180, 16'h0100);
    data(io, (len + 1) / 2);
    wait_start(s0);
    chk(o_tx_len, el);
    chk({15'h0000, o_tx_crc_append}, {15'h0000, ec});
    s0 = n_done;
    for (i = 0; i < 3000 && n_done == s0; i = i + 1)
      @(posedge i_sys_clk);
    chk(widx[15:0], nwords);
    // One edge so the result has reached the event flags
    @(posedge i_sys_clk);
    chk({15'h0000, o_intrq}, {15'h0000, txie && r == 2'd0});
    rd(io, io ? {8'h00, `IO_ISQ} : `OFS_ISQ, rv);
    chk(rv, `CODE_TX_EVENT | (16'h0001 << (r == 0 ? 8 : r == 1 ? 15 : r == 2 ? 10 : 9)));
  end
  endtask
  task t_frames;
  begin
    rd(1'b0, 12'h300, rv);
    chk(rv, 16'h0000);
    send(1'b0, 16'h30C0, 16'd3, 16'd3, 1'b0, 2'd0);
    send(1'b1, 16'h00C0, 16'd10, 16'd60, 1'b1, 2'd1);
    send(1'b0, 16'h10C0, 16'd20, 16'd60, 1'b0, 2'd2);
    send(1'b1, 16'h1080, 16'd1516, 16'd1516, 1'b0, 2'd3);
    wr(1'b0, `OFS_TX_IRQ_CFG, 16'h0100);
    txie = 1'b1;
    send(1'b0, 16'h0040, 16'd1514, 16'd1514, 1'b1, 2'd0);
    wr(1'b0, `OFS_TX_IRQ_CFG, 16'h0000);
    txie = 1'b0;
  end
  endtask
  task t_bid_err;
  begin
    bid(1'b0, 16'h00C0, 16'd2);
    stat(1'b0, rv);
    chk(rv & 16'h0080, 16'h0080);
    bid(1'b0, 16'h00C0, 16'd1515);
    stat(1'b0, rv);
    chk(rv & 16'h0080, 16'h0080);
    bid(1'b0, 16'h10C0, 16'd1519);
    stat(1'b0, rv);
    chk(rv & 16'h0080, 16'h0080);
  end
  endtask
  // Start after 5 bytes, then the host stops short of the frame
  task t_underrun;
    integer i, a0;
  begin
    a0 = n_abort;
    nwords <= 16'd32;
    bid(1'b0, 16'h0000, 16'd64);
    stat(1'b0, rv);
    data(1'b0, 3);
    for (i = 0; i < 200 && n_abort == a0; i = i + 1)
      @(posedge i_sys_clk);
    chk(n_abort - a0, 16'h0001);
    chk(widx[15:0], 16'h0003);
    rd(1'b0, `OFS_ISQ, rv);
    chk(rv, `CODE_BUF_EVENT | 16'h0200);
  end
  endtask
  task t_flush;
    integer s0, a0;
  begin
    s0 = n_start;
    a0 = n_abort;
    bid(1'b1, 16'h00C0, 16'd64);
    stat(1'b1, rv);
    data(1'b1, 2);
    bid(1'b1, 16'h0100, 16'd0);
    repeat (4) @(posedge i_sys_clk);
    chk(n_abort - a0, 16'h0001);
    chk(n_start - s0, 16'h0000);
    send(1'b1, 16'h00C0, 16'd64, 16'd64, 1'b1, 2'd0);
  end
  endtask
  // Second bid while the line is busy takes the interrupt path
  task t_irq;
    integer i;
  begin
    wr(1'b0, `OFS_BUF_IRQ_CFG, 16'h0100);
    gap <= 8'd40;
    nwords <= 16'd8;
    res <= 2'd0;
    i = n_start;
    bid(1'b0, 16'h00C0, 16'd16);
    stat(1'b0, rv);
    data(1'b0, 8);
    wait_start(i);
    bid(1'b0, 16'h00C0, 16'd16);
    stat(1'b0, rv);
    chk(rv & 16'h0180, 16'h0000);
    for (i = 0; i < 2000 && o_intrq !== 1'b1; i = i + 1)
      @(posedge i_sys_clk);
    chk({15'h0000, o_intrq}, 16'h0001);
    chk(widx[15:0], 16'd8);
    rd(1'b0, `OFS_ISQ, rv);
    chk(rv, `CODE_BUF_EVENT | 16'h0100);
    rd(1'b0, `OFS_ISQ, rv);
    chk(rv, `CODE_TX_EVENT | 16'h0100);
    chk({15'h0000, o_intrq}, 16'h0000);
    i = n_start;
    data(1'b0, 8);
    wait_start(i);
  end
  endtask
  task test_done;
  begin
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_frames;
    t_bid_err;
    t_underrun;
    t_flush;
    t_irq;
    test_done;
  end
  // Watchdog, the whole run needs far fewer cycles
  initial
  begin
    #4000000;
    n_mismatch = n_mismatch + 1;
    $display("ERROR %0t run did not finish", $time);
    test_done;
  end
endmodule
bind tx_request_buffer_commit tx_req_asserts tx_req_asserts_inst (.i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst), .i_io_sel(i_io_sel), .i_addr(i_addr), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_tx_start(o_tx_start),
  .o_tx_len(o_tx_len), .o_tx_crc_append(o_tx_crc_append), .o_tx_abort(o_tx_abort),
  .i_tx_word_req(i_tx_word_req), .o_tx_word_valid(o_tx_word_valid));
